// ==== hdl/sls_sequencer.sv ====
// status lamp sequencer: phase and button hold to green and red lamps
// assumes phase and status come from logic on clock_i, button from a pin
// Function
// - power-up: green off, red on, under 1 s
// - bad card: green 2500/250, red 250/2500
// - boot loader start: green on, red off
// - firmware update: red flashes 1 Hz, then restart
// - boot halt: green off, red on, no OS
// - boot loader done: both lamps off
// - OS start green only; done both on
// - drive update: green on, red flashes 1 Hz
// - unmount: red flickers 100/100, restart after 10 s if no booster fitted
// - feature start: green burst, red on
// - network handler start: green burst, red off
// - normal: green flashes 1 Hz, red off
// - booster unlinked: both flash until linked
// - button held: red on, off 5-10 s, on
// - release runs selected function, green stops flashing
// - shutdown done: green off, red on
// - communication down or no power: both off
`timescale 1ns/1ps
module sls_sequencer #(
	parameter int MS_CYCLES = sls_pkg::MS_CYCLES,
	parameter int POR_MS = sls_pkg::POR_MS
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// system phase and events
	input sls_pkg::sls_phase_type phase_i,
	input sls_pkg::sls_status_type status_i,
	input wire logic fw_done_i,
	// reset push-button pin, high while pressed
	input wire logic button_i,
	// lamps
	output sls_pkg::sls_lamp_type lamps_o,
	// functions started
	output sls_pkg::sls_func_type func_o,
	output logic func_valid_o,
	output logic restart_o,
	output logic os_start_ok_o
);

	initial begin
		if (MS_CYCLES < 2 || POR_MS < 1 || POR_MS >= sls_pkg::MS_PER_S)
			$error("sls_sequencer: bad timing parameters");
	end

	// ****************************************
	// millisecond tick
	// ****************************************
	localparam int TW = $clog2(MS_CYCLES);
	logic [TW-1:0] tick_cnt_q;
	logic tick;
	assign tick = (tick_cnt_q == TW'(MS_CYCLES - 1));

	always_ff @(posedge clock_i) begin
		if (!rst_b_i || tick)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + TW'(1);
	end

	// ****************************************
	// pattern counters
	// ****************************************
	logic [sls_pkg::PAT_W-1:0] pat_q [sls_pkg::NPAT];

	generate
		for (genvar i = 0; i < sls_pkg::NPAT; i++) begin : g_pat
			localparam logic [sls_pkg::PAT_W-1:0] LAST =
				sls_pkg::PAT_W'(sls_pkg::PERIOD_MS[i] - 1);
			always_ff @(posedge clock_i) begin
				if (!rst_b_i)
					pat_q[i] <= '0;
				else if (tick)
					pat_q[i] <= (pat_q[i] == LAST) ? '0 :
						pat_q[i] + sls_pkg::PAT_W'(1);
			end
		end
	endgenerate

	// three on/off pulses, then a gap
	function automatic logic burst_on(input logic [sls_pkg::PAT_W-1:0] c);
		logic [sls_pkg::PAT_W-1:0] slot;
		slot = sls_pkg::PAT_W'(c / sls_pkg::FLICK_MS);
		burst_on = (c < sls_pkg::PAT_W'(sls_pkg::BURST_ON_MS)) && !slot[0];
	endfunction

	logic flash, card_g, card_r, flick, burst;
	assign flash = pat_q[sls_pkg::PAT_FLASH] <
		sls_pkg::PAT_W'(sls_pkg::FLASH_HALF_MS);
	assign card_g = pat_q[sls_pkg::PAT_CARD] <
		sls_pkg::PAT_W'(sls_pkg::CARD_LONG_MS);
	assign card_r = !card_g;
	assign flick = pat_q[sls_pkg::PAT_FLICK] <
		sls_pkg::PAT_W'(sls_pkg::FLICK_MS);
	assign burst = burst_on(pat_q[sls_pkg::PAT_BURST]);

	// ****************************************
	// button synchroniser
	// ****************************************
	logic btn_meta_q, btn_q;

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			btn_meta_q <= 1'b0;
			btn_q <= 1'b0;
		end else begin
			btn_meta_q <= button_i;
			btn_q <= btn_meta_q;
		end
	end

	// ****************************************
	// sequencer state
	// ****************************************
	sls_pkg::sls_state_type state_q;
	logic [9:0] por_ms_q;
	logic [sls_pkg::HOLD_W-1:0] hold_ms_q;
	sls_pkg::sls_func_type sel_fn;
	logic normal, release_ev;

	assign normal = (phase_i == sls_pkg::PH_NORMAL);
	assign release_ev = (state_q == sls_pkg::ST_HOLD) && !btn_q;

	always_comb begin
		if (hold_ms_q < sls_pkg::HOLD_W'(sls_pkg::HOLD_SHUT_MS))
			sel_fn = sls_pkg::FN_RESTART;
		else if (hold_ms_q < sls_pkg::HOLD_W'(sls_pkg::HOLD_RELOAD_MS))
			sel_fn = sls_pkg::FN_SHUTDOWN;
		else
			sel_fn = sls_pkg::FN_RELOAD;
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i)
			por_ms_q <= '0;
		else if (state_q == sls_pkg::ST_POR && tick)
			por_ms_q <= por_ms_q + 10'(1);
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			state_q <= sls_pkg::ST_POR;
		end else begin
			unique case (state_q)
			sls_pkg::ST_POR:
				if (tick && por_ms_q == 10'(POR_MS - 1))
					state_q <= sls_pkg::ST_RUN;
			sls_pkg::ST_RUN:
				if (normal && btn_q)
					state_q <= sls_pkg::ST_HOLD;
			sls_pkg::ST_HOLD:
				if (!btn_q)
					state_q <= sls_pkg::ST_EXEC;
				else if (!normal)
					state_q <= sls_pkg::ST_RUN;
			sls_pkg::ST_EXEC:
				if (!normal)
					state_q <= sls_pkg::ST_RUN;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i || state_q == sls_pkg::ST_RUN)
			hold_ms_q <= '0;
		else if (state_q == sls_pkg::ST_HOLD && tick && !(&hold_ms_q))
			hold_ms_q <= hold_ms_q + sls_pkg::HOLD_W'(1);
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			func_o <= sls_pkg::FN_NONE;
			func_valid_o <= 1'b0;
		end else begin
			func_valid_o <= release_ev;
			if (release_ev)
				func_o <= sel_fn;
		end
	end

	// ****************************************
	// restart and boot halt
	// ****************************************
	logic [sls_pkg::HOLD_W-1:0] unm_ms_q;
	logic unm_run, unm_exp;

	assign unm_run = (phase_i == sls_pkg::PH_USB_UNMOUNT) &&
		!status_i.booster_fitted;
	assign unm_exp = unm_run && tick &&
		unm_ms_q == sls_pkg::HOLD_W'(sls_pkg::UNMOUNT_MS - 1);

	always_ff @(posedge clock_i) begin
		if (!rst_b_i || !unm_run)
			unm_ms_q <= '0;
		else if (tick && unm_ms_q != sls_pkg::HOLD_W'(sls_pkg::UNMOUNT_MS))
			unm_ms_q <= unm_ms_q + sls_pkg::HOLD_W'(1);
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i)
			restart_o <= 1'b0;
		else
			restart_o <= unm_exp || (fw_done_i &&
				phase_i == sls_pkg::PH_FIRMWARE_UPDATE);
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i)
			os_start_ok_o <= 1'b1;
		else if (phase_i == sls_pkg::PH_BOOT_HALT)
			os_start_ok_o <= 1'b0;
	end

	// ****************************************
	// lamp decode
	// ****************************************
	sls_pkg::sls_lamp_type lamp_d;
	logic hold_red;

	assign hold_red = (sel_fn != sls_pkg::FN_SHUTDOWN);

	always_comb begin
		lamp_d = '{green: 1'b0, red: 1'b0};
		if (state_q == sls_pkg::ST_POR) begin
			lamp_d = '{green: 1'b0, red: 1'b1};
		end else if (status_i.card_bad) begin
			lamp_d = '{green: card_g, red: card_r};
		end else begin
			unique case (phase_i)
			sls_pkg::PH_BOOT_LOADER, sls_pkg::PH_OS_START:
				lamp_d = '{green: 1'b1, red: 1'b0};
			sls_pkg::PH_FIRMWARE_UPDATE, sls_pkg::PH_USB_UPDATE:
				lamp_d = '{green: 1'b1, red: flash};
			sls_pkg::PH_BOOT_HALT, sls_pkg::PH_SHUT_DONE:
				lamp_d = '{green: 1'b0, red: 1'b1};
			sls_pkg::PH_OS_DONE:
				lamp_d = '{green: 1'b1, red: 1'b1};
			sls_pkg::PH_USB_UNMOUNT:
				lamp_d = '{green: 1'b1, red: flick};
			sls_pkg::PH_FEATURE_START:
				lamp_d = '{green: burst, red: 1'b1};
			sls_pkg::PH_LAN_START:
				lamp_d = '{green: burst, red: 1'b0};
			sls_pkg::PH_NORMAL:
				if (state_q == sls_pkg::ST_HOLD)
					lamp_d = '{green: flash, red: hold_red};
				else if (state_q == sls_pkg::ST_EXEC)
					lamp_d = '{green: 1'b0, red: hold_red};
				else if (status_i.booster_fitted &&
					!status_i.booster_link)
					lamp_d = '{green: flash, red: flash};
				else
					lamp_d = '{green: flash, red: 1'b0};
			default:
				lamp_d = '{green: 1'b0, red: 1'b0};
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i)
			lamps_o <= '{green: 1'b0, red: 1'b1};
		else
			lamps_o <= lamp_d;
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);

	logic run_plain;
	assign run_plain = state_q != sls_pkg::ST_POR && !status_i.card_bad;

	property p_por;
		state_q == sls_pkg::ST_POR |=> !lamps_o.green && lamps_o.red;
	endproperty
	a_por: assert property (p_por) else $error("power-up lamps wrong");

	property p_card;
		state_q != sls_pkg::ST_POR && status_i.card_bad
			|=> lamps_o.green == $past(card_g) && lamps_o.red != lamps_o.green;
	endproperty
	a_card: assert property (p_card) else $error("card pattern wrong");

	property p_boot;
		run_plain && phase_i == sls_pkg::PH_BOOT_LOADER
			|=> lamps_o.green && !lamps_o.red;
	endproperty
	a_boot: assert property (p_boot) else $error("boot lamps wrong");

	property p_halt;
		phase_i == sls_pkg::PH_BOOT_HALT |=> !os_start_ok_o [*2];
	endproperty
	a_halt: assert property (p_halt) else $error("halt not held");

	property p_os_done;
		run_plain && phase_i == sls_pkg::PH_OS_DONE
			|=> lamps_o.green && lamps_o.red;
	endproperty
	a_os_done: assert property (p_os_done) else $error("os done wrong");

	property p_unmount;
		unm_exp |=> restart_o ##1 !restart_o;
	endproperty
	a_unmount: assert property (p_unmount) else $error("no restart");

	property p_normal;
		run_plain && normal && state_q == sls_pkg::ST_RUN &&
			!status_i.booster_fitted |=> !lamps_o.red;
	endproperty
	a_normal: assert property (p_normal) else $error("red in normal");

	property p_hold;
		run_plain && normal && state_q == sls_pkg::ST_HOLD &&
			hold_ms_q >= sls_pkg::HOLD_W'(sls_pkg::HOLD_SHUT_MS) &&
			hold_ms_q < sls_pkg::HOLD_W'(sls_pkg::HOLD_RELOAD_MS)
			|=> !lamps_o.red;
	endproperty
	a_hold: assert property (p_hold) else $error("hold red wrong");

	property p_release;
		release_ev |=> func_valid_o && func_o == $past(sel_fn) &&
			state_q == sls_pkg::ST_EXEC;
	endproperty
	a_release: assert property (p_release) else $error("release lost");

	c_release: cover property (release_ev && sel_fn == sls_pkg::FN_SHUTDOWN);
	c_card: cover property (run_plain ##1 status_i.card_bad);
	c_unmount: cover property (unm_exp);
	c_fw: cover property (restart_o && !unm_run);

endmodule

// ==== hdl/sls_pkg.sv ====
// constants, types and carriers of the status lamp sequencer
// assumes a 200 MHz system clock and a one millisecond time base
package sls_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 200_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
	localparam int POR_MS = 500;
	localparam int HOLD_SHUT_MS = 5000;
	localparam int HOLD_RELOAD_MS = 10000;
	localparam int UNMOUNT_MS = 10000;

	// ****************************************
	// blink patterns, milliseconds
	// ****************************************
	localparam int FLASH_HALF_MS = 500;
	localparam int CARD_LONG_MS = 2500;
	localparam int CARD_SHORT_MS = 250;
	localparam int FLICK_MS = 100;
	localparam int BURST_PULSES = 3;
	localparam int BURST_GAP_MS = 500;
	localparam int BURST_ON_MS = 2 * FLICK_MS * BURST_PULSES;
	localparam int NPAT = 4;
	localparam int PAT_FLASH = 0;
	localparam int PAT_CARD = 1;
	localparam int PAT_FLICK = 2;
	localparam int PAT_BURST = 3;
	localparam int PAT_W = 12;
	localparam int PERIOD_MS [NPAT] = '{2 * FLASH_HALF_MS,
		CARD_LONG_MS + CARD_SHORT_MS, 2 * FLICK_MS,
		BURST_ON_MS + BURST_GAP_MS};
	localparam int HOLD_W = 16;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [3:0] {
		PH_NO_POWER = 4'h0,
		PH_BOOT_LOADER = 4'h1,
		PH_FIRMWARE_UPDATE = 4'h2,
		PH_BOOT_HALT = 4'h3,
		PH_BOOT_DONE = 4'h4,
		PH_OS_START = 4'h5,
		PH_OS_DONE = 4'h6,
		PH_USB_UPDATE = 4'h7,
		PH_USB_UNMOUNT = 4'h8,
		PH_FEATURE_START = 4'h9,
		PH_LAN_START = 4'ha,
		PH_NORMAL = 4'hb,
		PH_SHUT_DONE = 4'hc,
		PH_COMM_DOWN = 4'hd
	} sls_phase_type;

	typedef struct packed {
		logic card_bad;
		logic booster_fitted;
		logic booster_link;
	} sls_status_type;

	typedef struct packed {
		logic green;
		logic red;
	} sls_lamp_type;

	typedef enum logic [1:0] {
		FN_NONE = 2'h0,
		FN_RESTART = 2'h1,
		FN_SHUTDOWN = 2'h2,
		FN_RELOAD = 2'h3
	} sls_func_type;

	typedef enum logic [1:0] {
		ST_POR = 2'h0,
		ST_RUN = 2'h1,
		ST_HOLD = 2'h3,
		ST_EXEC = 2'h2
	} sls_state_type;

endpackage

// ==== test/sls_lamp_watch.sv ====
// lamp watcher: counts lit cycles of each lamp since the last clear
// assumes lamps are registered on clock_i; clear before every window
`timescale 1ns/1ps
module sls_lamp_watch (
	// clock and control
	input wire logic clock_i,
	input wire logic clear_i,
	// lamps seen by the technician
	input sls_pkg::sls_lamp_type lamps_i,
	// lit cycle counts
	output logic [15:0] green_cnt_o,
	output logic [15:0] red_cnt_o
);
	always_ff @(posedge clock_i) begin
		if (clear_i) begin
			green_cnt_o <= 16'h0000;
			red_cnt_o <= 16'h0000;
		end else begin
			green_cnt_o <= green_cnt_o + {15'h0000, lamps_i.green};
			red_cnt_o <= red_cnt_o + {15'h0000, lamps_i.red};
		end
	end
endmodule

// ==== test/sls_sequencer_test.sv ====
// self-checking bench of the status lamp sequencer
// assumes short ms tick (2 cycles) and 2 ms power-up in the design
`timescale 1ns/1ps
module sls_sequencer_test;
	localparam int MSC = 2;
	localparam int FL = 1000 * MSC;
	logic clock_i;
	logic rst_b_i;
	sls_pkg::sls_phase_type phase_i;
	sls_pkg::sls_status_type status_i;
	logic fw_done_i;
	logic button_i;
	sls_pkg::sls_lamp_type lamps_o;
	sls_pkg::sls_func_type func_o;
	logic func_valid_o;
	logic restart_o;
	logic os_start_ok_o;
	logic clear, meas_done;
	logic [15:0] g_cnt, r_cnt;
	logic [31:0] exp_q[$];
	int fail_count, n_compared, i;
	time t0;
	integer seed = 32'hb4e77453;
	sls_pkg::sls_phase_type ph_tab[8] = '{sls_pkg::PH_BOOT_LOADER,
		sls_pkg::PH_BOOT_HALT, sls_pkg::PH_BOOT_DONE, sls_pkg::PH_OS_START,
		sls_pkg::PH_OS_DONE, sls_pkg::PH_SHUT_DONE, sls_pkg::PH_COMM_DOWN,
		sls_pkg::PH_NO_POWER};
	logic [1:0] lp_tab[8] = '{2'h2, 2'h1, 2'h0, 2'h2, 2'h3, 2'h1, 2'h0, 2'h0};

	sls_sequencer #(.MS_CYCLES(MSC), .POR_MS(2)) uut (.clock_i(clock_i),
		.rst_b_i(rst_b_i), .phase_i(phase_i), .status_i(status_i),
		.fw_done_i(fw_done_i), .button_i(button_i), .lamps_o(lamps_o),
		.func_o(func_o), .func_valid_o(func_valid_o),
		.restart_o(restart_o), .os_start_ok_o(os_start_ok_o));
	sls_lamp_watch watch (.clock_i(clock_i), .clear_i(clear),
		.lamps_i(lamps_o), .green_cnt_o(g_cnt), .red_cnt_o(r_cnt));

	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen,
				exp);
		end
	endtask
	task automatic take(input logic [31:0] seen);
		if (exp_q.size() == 0) begin
			fail_count++;
			$display("wrong value at %0t: unexpected %h", $time, seen);
		end else begin
			check(seen, exp_q.pop_front());
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task automatic set(input sls_pkg::sls_phase_type p, input logic [2:0] s);
		@(posedge clock_i);
		phase_i <= p;
		status_i <= s;
		t0 = $time;
		tick(3);
	endtask
	task automatic measure(input int win, input int g, input int r);
		exp_q.push_back({g[15:0], r[15:0]});
		@(posedge clock_i);
		clear <= 1'b1;
		@(posedge clock_i);
		clear <= 1'b0;
		tick(win);
		meas_done <= 1'b1;
		@(posedge clock_i);
		meas_done <= 1'b0;
	endtask
	task automatic press(input int n, input sls_pkg::sls_func_type f);
		@(posedge clock_i);
		button_i <= 1'b1;
		tick(n);
		button_i <= 1'b0;
		exp_q.push_back({30'h0, f});
		for (i = 0; i < 20 && func_valid_o !== 1'b1; i++) begin
			@(posedge clock_i);
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ****************************************
	// clock, result watcher, watchdog
	// ****************************************
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		if (meas_done) take({g_cnt, r_cnt});
		if (func_valid_o) take({30'h0, func_o});
		if (restart_o) take(32'h1);
	end
	initial begin
		#500000;
		fail_count++;
		tally_and_finish();
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		rst_b_i = 1'b0;
		phase_i = sls_pkg::PH_OS_DONE;
		status_i = 3'h0;
		fw_done_i = 1'b0;
		button_i = 1'b0;
		clear = 1'b0;
		meas_done = 1'b0;
		tick(3);
		rst_b_i <= 1'b1;
		tick(2);
		check({30'h0, lamps_o}, 32'h1);
		check({31'h0, os_start_ok_o}, 32'h1);
		tick(10);
		check({30'h0, lamps_o}, 32'h3);
		$display("power-up test done");
		for (int k = 0; k < 8; k++) begin
			set(ph_tab[k], {1'b0, 2'($random(seed))});
			measure(100, lp_tab[k][1] ? 100 : 0, lp_tab[k][0] ? 100 : 0);
		end
		check({31'h0, os_start_ok_o}, 32'h0);
		$display("steady lamp test done");
		set(sls_pkg::PH_NORMAL, 3'h4);
		measure(2750 * MSC, 2500 * MSC, 250 * MSC);
		set(sls_pkg::PH_FEATURE_START, 3'h0);
		measure(1100 * MSC, 300 * MSC, 1100 * MSC);
		set(sls_pkg::PH_LAN_START, 3'h0);
		measure(1100 * MSC, 300 * MSC, 0);
		set(sls_pkg::PH_USB_UPDATE, 3'h0);
		measure(FL, FL, FL / 2);
		set(sls_pkg::PH_NORMAL, 3'h2);
		measure(FL, FL / 2, FL / 2);
		set(sls_pkg::PH_NORMAL, 3'h3);
		measure(FL, FL / 2, 0);
		$display("blink pattern test done");
		set(sls_pkg::PH_FIRMWARE_UPDATE, 3'h0);
		measure(FL, FL, FL / 2);
		exp_q.push_back(32'h1);
		fw_done_i <= 1'b1;
		@(posedge clock_i);
		fw_done_i <= 1'b0;
		set(sls_pkg::PH_NORMAL, 3'h0);
		fw_done_i <= 1'b1;
		@(posedge clock_i);
		fw_done_i <= 1'b0;
		set(sls_pkg::PH_USB_UNMOUNT, 3'h0);
		measure(200 * MSC, 200 * MSC, 100 * MSC);
		exp_q.push_back(32'h1);
		for (i = 0; i < 50000 && restart_o !== 1'b1; i++) begin
			@(posedge clock_i);
		end
		i = int'(($time - t0) / 5);
		check({31'h0, (i >= sls_pkg::UNMOUNT_MS * MSC - 2 &&
			i <= sls_pkg::UNMOUNT_MS * MSC + 10)}, 32'h1);
		$display("restart test done");
		set(sls_pkg::PH_OS_DONE, 3'h0);
		press(50, sls_pkg::FN_NONE);
		void'(exp_q.pop_back());
		set(sls_pkg::PH_NORMAL, 3'h0);
		@(posedge clock_i);
		button_i <= 1'b1;
		tick(4000 * MSC);
		check({31'h0, lamps_o.red}, 32'h1);
		tick(3000 * MSC);
		check({31'h0, lamps_o.red}, 32'h0);
		press(3020 * MSC, sls_pkg::FN_RELOAD);
		check({31'h0, lamps_o.red}, 32'h1);
		measure(500 * MSC, 0, 500 * MSC);
		set(sls_pkg::PH_BOOT_LOADER, 3'h0);
		set(sls_pkg::PH_NORMAL, 3'h0);
		press(100 * MSC, sls_pkg::FN_RESTART);
		set(sls_pkg::PH_BOOT_LOADER, 3'h0);
		set(sls_pkg::PH_NORMAL, 3'h0);
		press(7000 * MSC, sls_pkg::FN_SHUTDOWN);
		check({31'h0, lamps_o.red}, 32'h0);
		measure(100, 0, 0);
		$display("button test done");
		tick(10);
		check(exp_q.size(), 32'h0);
		tally_and_finish();
	end
endmodule
